// [usb_pipe_pkg.sv]
// package: register map, field layout and constants of the pipe FIFO port
package usb_pipe_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam int         AW           = 6;
  localparam logic [5:0] OFS_PORT_CTRL = 6'h00;
  localparam logic [5:0] OFS_PORT_DATA = 6'h04;
  localparam logic [5:0] OFS_PIPE_SEL  = 6'h08;
  localparam logic [5:0] OFS_PIPE_CFG  = 6'h0C;
  localparam logic [5:0] OFS_PIPE_BUF  = 6'h10;
  localparam logic [5:0] OFS_PORT_STAT = 6'h14;
  localparam logic [5:0] OFS_HOST_BASE = 6'h20;
  localparam logic [5:0] OFS_IRQ_STAT  = 6'h20;
  localparam logic [5:0] OFS_IRQ_MASK  = 6'h24;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int PC_PIPE_LSB  = 0;
  localparam int PC_ORDER_BIT = 8;
  localparam int PC_WIDTH_LSB = 10;
  localparam int PC_CLR_BIT   = 14;
  localparam int CFG_EP_LSB   = 0;
  localparam int CFG_DIR_BIT  = 4;
  localparam int CFG_CONT_BIT = 7;
  localparam int CFG_ADIS_BIT = 8;
  localparam int CFG_DBL_BIT  = 9;
  localparam int CFG_RDY_BIT  = 10;
  localparam int CFG_TYPE_LSB = 14;
  localparam int BUF_AREA_LSB = 0;
  localparam int BUF_SIZE_LSB = 10;
  localparam int STAT_SIZE_LSB = 16;
  localparam int IRQ_W        = 3;
  localparam int IRQ_RDY      = 0;
  localparam int IRQ_DEV_REJ  = 1;
  localparam int IRQ_HOST_REJ = 2;

  typedef enum logic [1:0] {
    W8   = 2'h0,
    W16  = 2'h1,
    W32  = 2'h2,
    WBAD = 2'h3
  } width_t;

  typedef enum logic [1:0] {
    T_NONE = 2'h0,
    T_BULK = 2'h1,
    T_INTR = 2'h2,
    T_ISO  = 2'h3
  } xfer_t;

  // ----------------------------------------------------------------------
  // pipes and buffer areas
  // ----------------------------------------------------------------------
  localparam int          NUM_PIPES    = 10;
  localparam logic [3:0]  CTRL_PIPE    = 4'h0;
  localparam logic [3:0]  LAST_PIPE    = 4'h9;
  localparam logic [3:0]  BIG_LO       = 4'h1;
  localparam logic [3:0]  BIG_HI       = 4'h5;
  localparam logic [3:0]  BULK_ONLY_HI = 4'h2;
  localparam logic [3:0]  CONT_LO      = 4'h3;
  localparam logic [3:0]  SMALL_LO     = 4'h6;
  localparam logic [11:0] CTRL_BYTES   = 12'h100;
  localparam logic [11:0] SMALL_BYTES  = 12'h040;
  localparam int          AREA_SHIFT   = 6;
  localparam logic [12:0] SMALL_AREA0  = 13'h0004;
  localparam logic [6:0]  AREA_MIN     = 7'h08;
  localparam logic [3:0]  DIR_TX       = 4'h1;

endpackage : usb_pipe_pkg

// [fifo_port_if.sv]
// interface: FIFO port and pipe register path between CPU side and pipe logic
`timescale 1ns/1ps
interface fifo_port_if;
  logic        req;      // access strobe, one cycle
  logic        wr;       // 1 write, 0 read
  logic [5:0]  addr;     // byte offset
  logic [31:0] wdata;    // write data
  logic [3:0]  be;       // byte lanes of a data write
  logic [31:0] rdata;    // read data, same cycle as req
  logic        rej;      // write refused, same cycle as req
  logic        rdy_evt;  // buffer boundary reached, pulse

  modport dev  (input req, wr, addr, wdata, be,
                output rdata, rej, rdy_evt);
  modport host (output req, wr, addr, wdata, be,
                input rdata, rej, rdy_evt);
endinterface : fifo_port_if

// [usb_pipe_dev.sv]
// module: pipe configuration, FIFO port control and pipe buffer memory
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module usb_pipe_dev #(
  parameter int MEM_BYTES = 8192
) (
  input  wire logic  sys_clk,  // 20 MHz system clock
  input  wire logic  rst,      // asynchronous reset, active high
  fifo_port_if.dev   bus       // access path from the CPU side
);

  localparam int MA = $clog2(MEM_BYTES);
  localparam int NP = usb_pipe_pkg::NUM_PIPES;

  // ------------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------------
  usb_pipe_pkg::width_t width_r;
  logic                 order_r;
  logic [3:0]           sel_r;
  logic [3:0]           cfgsel_r;
  logic [15:0]          cfg_r [NP];
  logic [15:0]          buf_r [NP];
  logic [11:0]          ptr_r [NP];
  logic [7:0]           mem   [MEM_BYTES];

  // ------------------------------------------------------------------------
  // capability decoding
  // ------------------------------------------------------------------------
  function automatic logic in_rng(input logic [3:0] p, input logic [3:0] lo,
                                  input logic [3:0] hi);
    return (p >= lo) && (p <= hi);
  endfunction : in_rng

  function automatic logic may_cont(input logic [3:0] p,
                                    input logic [1:0] t);
    return in_rng(p, usb_pipe_pkg::CONT_LO, usb_pipe_pkg::BIG_HI)
        || (in_rng(p, usb_pipe_pkg::BIG_LO, usb_pipe_pkg::BULK_ONLY_HI)
            && t == usb_pipe_pkg::T_BULK);
  endfunction : may_cont

  function automatic logic [11:0] pipe_bytes(input logic [3:0]  p,
                                             input logic [15:0] b);
    logic [11:0] s;
    s = usb_pipe_pkg::SMALL_BYTES;
    if (p == usb_pipe_pkg::CTRL_PIPE) begin
      s = usb_pipe_pkg::CTRL_BYTES;
    end else if (in_rng(p, usb_pipe_pkg::BIG_LO, usb_pipe_pkg::BIG_HI)) begin
      s = 12'({1'b0, b[usb_pipe_pkg::BUF_SIZE_LSB +: 5]} + 6'h01)
          << usb_pipe_pkg::AREA_SHIFT;
    end
    return s;
  endfunction : pipe_bytes

  function automatic logic [12:0] pipe_base(input logic [3:0]  p,
                                            input logic [15:0] b);
    logic [12:0] a;
    a = 13'h0000;
    if (in_rng(p, usb_pipe_pkg::BIG_LO, usb_pipe_pkg::BIG_HI)) begin
      a = {6'h00, b[usb_pipe_pkg::BUF_AREA_LSB +: 7]};
    end else if (p >= usb_pipe_pkg::SMALL_LO) begin
      a = {9'h000, p} - {9'h000, usb_pipe_pkg::SMALL_LO}
          + usb_pipe_pkg::SMALL_AREA0;
    end
    return a << usb_pipe_pkg::AREA_SHIFT;
  endfunction : pipe_base

  function automatic logic [2:0] full_bytes(input usb_pipe_pkg::width_t w);
    logic [2:0] n;
    n = 3'h4;
    if (w == usb_pipe_pkg::W8) begin
      n = 3'h1;
    end else if (w == usb_pipe_pkg::W16) begin
      n = 3'h2;
    end
    return n;
  endfunction : full_bytes

  // ------------------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------------------
  logic        wr_en, rd_data, wr_data, wr_ctrl, wr_cfg, wr_buf, wr_sel;
  logic        ctrl_bad, end_hit;
  logic [2:0]  n_full, n_be, n_wr, n_acc;
  logic [11:0] size_c, ptr_c;
  logic [12:0] base_c;
  logic [15:0] cfg_nxt, buf_nxt;
  logic [1:0]  type_nxt;
  logic [3:0]  p_cfg, sel_nxt;
  usb_pipe_pkg::width_t w_new;

  assign wr_en   = bus.req && bus.wr;
  assign wr_data = wr_en && bus.addr == usb_pipe_pkg::OFS_PORT_DATA;
  assign rd_data = bus.req && !bus.wr
                   && bus.addr == usb_pipe_pkg::OFS_PORT_DATA;
  assign wr_ctrl = wr_en && bus.addr == usb_pipe_pkg::OFS_PORT_CTRL;
  assign wr_cfg  = wr_en && bus.addr == usb_pipe_pkg::OFS_PIPE_CFG;
  assign wr_buf  = wr_en && bus.addr == usb_pipe_pkg::OFS_PIPE_BUF;
  assign wr_sel  = wr_en && bus.addr == usb_pipe_pkg::OFS_PIPE_SEL;

  assign size_c = pipe_bytes(sel_r, buf_r[sel_r]);
  assign base_c = pipe_base(sel_r, buf_r[sel_r]);
  assign ptr_c  = ptr_r[sel_r];
  assign n_full = full_bytes(width_r);
  // partial writes count contiguous low lanes, so odd totals are possible
  assign n_be   = !bus.be[0] ? 3'h0 : !bus.be[1] ? 3'h1 :
                  !bus.be[2] ? 3'h2 : !bus.be[3] ? 3'h3 : 3'h4;
  assign n_wr   = (n_be < n_full) ? n_be : n_full;
  assign n_acc  = wr_data ? n_wr : n_full;
  assign end_hit = (ptr_c + {9'h000, n_acc}) >= size_c;

  assign w_new   = usb_pipe_pkg::width_t'(
                     bus.wdata[usb_pipe_pkg::PC_WIDTH_LSB +: 2]);
  // a widening width on a transmit pipe holding data would misalign words
  assign ctrl_bad = w_new == usb_pipe_pkg::WBAD
      || (cfg_r[sel_r][usb_pipe_pkg::CFG_DIR_BIT]
          && ptr_c != 12'h000 && w_new > width_r);
  assign sel_nxt = (bus.wdata[3:0] <= usb_pipe_pkg::LAST_PIPE)
                   ? bus.wdata[3:0] : sel_r;

  assign bus.rej     = (wr_ctrl && ctrl_bad)
      || (wr_buf && in_rng(cfgsel_r, usb_pipe_pkg::BIG_LO,
                           usb_pipe_pkg::BIG_HI)
          && bus.wdata[usb_pipe_pkg::BUF_AREA_LSB +: 7]
             < usb_pipe_pkg::AREA_MIN);
  assign bus.rdy_evt = (wr_data || rd_data) && end_hit;

  // ------------------------------------------------------------------------
  // port control register
  // ------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      width_r <= usb_pipe_pkg::W8;
      order_r <= 1'b0;
      sel_r   <= usb_pipe_pkg::CTRL_PIPE;
    end else if (wr_ctrl) begin
      order_r <= bus.wdata[usb_pipe_pkg::PC_ORDER_BIT];
      sel_r   <= sel_nxt;
      if (!ctrl_bad) begin
        width_r <= w_new;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfgsel_r <= usb_pipe_pkg::CTRL_PIPE;
    end else if (wr_sel && bus.wdata[3:0] <= usb_pipe_pkg::LAST_PIPE) begin
      cfgsel_r <= bus.wdata[3:0];
    end
  end

  // ------------------------------------------------------------------------
  // pipe configuration; unsupported fields stay zero
  // ------------------------------------------------------------------------
  assign p_cfg = cfgsel_r;

  always_comb begin
    cfg_nxt  = 16'h0000;
    type_nxt = usb_pipe_pkg::T_NONE;
    cfg_nxt[usb_pipe_pkg::CFG_DIR_BIT] =
      bus.wdata[usb_pipe_pkg::CFG_DIR_BIT];
    if (p_cfg != usb_pipe_pkg::CTRL_PIPE) begin
      type_nxt = bus.wdata[usb_pipe_pkg::CFG_TYPE_LSB +: 2];
      cfg_nxt[usb_pipe_pkg::CFG_TYPE_LSB +: 2] = type_nxt;
      cfg_nxt[usb_pipe_pkg::CFG_EP_LSB +: 4] =
        bus.wdata[usb_pipe_pkg::CFG_EP_LSB +: 4];
    end
    if (in_rng(p_cfg, usb_pipe_pkg::BIG_LO, usb_pipe_pkg::BIG_HI)) begin
      cfg_nxt[usb_pipe_pkg::CFG_RDY_BIT] =
        bus.wdata[usb_pipe_pkg::CFG_RDY_BIT];
      cfg_nxt[usb_pipe_pkg::CFG_DBL_BIT] =
        bus.wdata[usb_pipe_pkg::CFG_DBL_BIT];
    end
    if (may_cont(p_cfg, type_nxt)) begin
      cfg_nxt[usb_pipe_pkg::CFG_CONT_BIT] =
        bus.wdata[usb_pipe_pkg::CFG_CONT_BIT];
      cfg_nxt[usb_pipe_pkg::CFG_ADIS_BIT] =
        bus.wdata[usb_pipe_pkg::CFG_ADIS_BIT];
    end
  end

  assign buf_nxt = {1'b0, bus.wdata[usb_pipe_pkg::BUF_SIZE_LSB +: 5],
                    3'h0, bus.wdata[usb_pipe_pkg::BUF_AREA_LSB +: 7]};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NP; i++) begin
        cfg_r[i] <= 16'h0000;
        buf_r[i] <= 16'h0000;
      end
    end else begin
      if (wr_cfg) begin
        cfg_r[p_cfg] <= cfg_nxt;
      end
      // only the large pipes own their size and area; others are fixed
      if (wr_buf && !bus.rej
          && in_rng(p_cfg, usb_pipe_pkg::BIG_LO, usb_pipe_pkg::BIG_HI)) begin
        buf_r[p_cfg] <= buf_nxt;
      end
    end
  end

  // ------------------------------------------------------------------------
  // buffer pointers; the pointer wraps when the buffer boundary is reached
  // ------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NP; i++) begin
        ptr_r[i] <= 12'h000;
      end
    end else if (wr_ctrl && bus.wdata[usb_pipe_pkg::PC_CLR_BIT]) begin
      ptr_r[sel_nxt] <= 12'h000;
    end else if (wr_data || rd_data) begin
      ptr_r[sel_r] <= end_hit ? 12'h000
                               : ptr_c + {9'h000, n_acc};
    end
  end

  // ------------------------------------------------------------------------
  // buffer memory, one writer per byte lane
  // ------------------------------------------------------------------------
  for (genvar k = 0; k < 4; k++) begin : g_lane
    logic [1:0]    lane;
    logic [MA-1:0] baddr;
    assign lane  = order_r ? 2'(n_wr - 3'(k + 1)) : 2'(k);
    assign baddr = MA'(base_c + {1'b0, ptr_c} + 13'(k));
    always_ff @(posedge sys_clk) begin
      if (wr_data && 3'(k) < n_wr
          && ptr_c + 12'(k) < size_c) begin
        mem[baddr] <= bus.wdata[8*lane +: 8];
      end
    end
  end

  // ------------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------------
  always_comb begin
    logic [1:0] ln;
    ln = 2'h0;
    bus.rdata = 32'h0000_0000;
    unique case (bus.addr)
      usb_pipe_pkg::OFS_PORT_CTRL: begin
        bus.rdata[usb_pipe_pkg::PC_WIDTH_LSB +: 2] = width_r;
        bus.rdata[usb_pipe_pkg::PC_ORDER_BIT]      = order_r;
        bus.rdata[usb_pipe_pkg::PC_PIPE_LSB +: 4]  = sel_r;
      end
      usb_pipe_pkg::OFS_PORT_DATA: begin
        for (int k = 0; k < 4; k++) begin
          ln = order_r ? 2'(n_full - 3'(k + 1)) : 2'(k);
          if (3'(k) < n_full) begin
            bus.rdata[8*ln +: 8] =
              mem[MA'(base_c + {1'b0, ptr_c} + 13'(k))];
          end
        end
      end
      usb_pipe_pkg::OFS_PIPE_SEL:  bus.rdata[3:0]  = cfgsel_r;
      usb_pipe_pkg::OFS_PIPE_CFG:  bus.rdata[15:0] = cfg_r[cfgsel_r];
      usb_pipe_pkg::OFS_PIPE_BUF: begin
        bus.rdata[15:0] = buf_r[cfgsel_r];
        if (cfgsel_r >= usb_pipe_pkg::SMALL_LO) begin
          bus.rdata[6:0] = 7'(pipe_base(cfgsel_r, 16'h0000)
                              >> usb_pipe_pkg::AREA_SHIFT);
        end
      end
      usb_pipe_pkg::OFS_PORT_STAT: begin
        bus.rdata[11:0] = ptr_c;
        bus.rdata[usb_pipe_pkg::STAT_SIZE_LSB +: 12] = size_c;
      end
      default: bus.rdata = 32'h0000_0000;
    endcase
  end

endmodule : usb_pipe_dev

// [usb_pipe_host.sv]
// module: CPU-side master of the FIFO port with guard checks and interrupts
`timescale 1ns/1ps
module usb_pipe_host (
  input  wire logic        sys_clk,    // 20 MHz system clock
  input  wire logic        rst,        // asynchronous reset, active high
  fifo_port_if.host        bus,        // path to the pipe logic
  input  wire logic [5:0]  sw_addr,    // software byte address
  input  wire logic [31:0] sw_wdata,   // software write data
  input  wire logic [3:0]  sw_be,      // byte lanes of a data write
  input  wire logic        sw_wr,      // write strobe
  input  wire logic        sw_rd,      // read strobe
  output logic      [31:0] sw_rdata,   // read data, cycle after sw_rd
  output logic             irq         // level interrupt
);

  localparam int NP = usb_pipe_pkg::NUM_PIPES;

  logic [31:0]           rdata_r;
  logic [usb_pipe_pkg::IRQ_W-1:0] stat_r, mask_r, ev;
  logic [3:0]            sel_sh_r, cfgsel_sh_r;
  logic [1:0]            width_sh_r;
  logic                  rx_lock_r;
  logic [NP-1:0]         ep_ok_r, dir_sh_r;
  logic                  dev_sel, is_data, is_ctrl, blk_w, blk_ep, blk;

  // ------------------------------------------------------------------------
  // guards on software accesses
  // ------------------------------------------------------------------------
  assign dev_sel = sw_addr < usb_pipe_pkg::OFS_HOST_BASE;
  assign is_data = sw_addr == usb_pipe_pkg::OFS_PORT_DATA;
  assign is_ctrl = sw_addr == usb_pipe_pkg::OFS_PORT_CTRL;
  // width must hold while a receive buffer is part way read
  assign blk_w   = sw_wr && is_ctrl && rx_lock_r
      && !sw_wdata[usb_pipe_pkg::PC_CLR_BIT]
      && sw_wdata[usb_pipe_pkg::PC_WIDTH_LSB +: 2] != width_sh_r;
  assign blk_ep  = (sw_wr || sw_rd) && is_data
      && sel_sh_r != usb_pipe_pkg::CTRL_PIPE && !ep_ok_r[sel_sh_r];
  assign blk     = blk_w || blk_ep;

  assign bus.req   = (sw_wr || sw_rd) && dev_sel && !blk;
  assign bus.wr    = sw_wr;
  assign bus.addr  = sw_addr;
  assign bus.wdata = sw_wdata;
  assign bus.be    = sw_be;

  // ------------------------------------------------------------------------
  // shadows of the pipe state the guards need
  // ------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_sh_r   <= usb_pipe_pkg::CTRL_PIPE;
      width_sh_r <= usb_pipe_pkg::W8;
      rx_lock_r  <= 1'b0;
    end else if (bus.req && bus.wr && is_ctrl) begin
      // pipe index and width arrive in one write, so they stay paired
      if (sw_wdata[3:0] <= usb_pipe_pkg::LAST_PIPE) begin
        sel_sh_r <= sw_wdata[3:0];
      end
      if (!bus.rej) begin
        width_sh_r <= sw_wdata[usb_pipe_pkg::PC_WIDTH_LSB +: 2];
      end
      rx_lock_r <= rx_lock_r && !sw_wdata[usb_pipe_pkg::PC_CLR_BIT];
    end else if (bus.req && !bus.wr && is_data) begin
      rx_lock_r <= !bus.rdy_evt && !dir_sh_r[sel_sh_r];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cfgsel_sh_r <= usb_pipe_pkg::CTRL_PIPE;
      ep_ok_r     <= '0;
      dir_sh_r    <= '0;
    end else if (bus.req && bus.wr) begin
      if (sw_addr == usb_pipe_pkg::OFS_PIPE_SEL
          && sw_wdata[3:0] <= usb_pipe_pkg::LAST_PIPE) begin
        cfgsel_sh_r <= sw_wdata[3:0];
      end
      if (sw_addr == usb_pipe_pkg::OFS_PIPE_CFG) begin
        ep_ok_r[cfgsel_sh_r]  <=
          sw_wdata[usb_pipe_pkg::CFG_EP_LSB +: 4] != 4'h0;
        dir_sh_r[cfgsel_sh_r] <= sw_wdata[usb_pipe_pkg::CFG_DIR_BIT];
      end
    end
  end

  // ------------------------------------------------------------------------
  // interrupt status and mask; a new event beats a clearing write
  // ------------------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[usb_pipe_pkg::IRQ_RDY]      = bus.req && bus.rdy_evt;
    ev[usb_pipe_pkg::IRQ_DEV_REJ]  = bus.req && bus.rej;
    ev[usb_pipe_pkg::IRQ_HOST_REJ] = blk;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
    end else if (sw_wr && sw_addr == usb_pipe_pkg::OFS_IRQ_STAT) begin
      stat_r <= (stat_r & ~sw_wdata[usb_pipe_pkg::IRQ_W-1:0]) | ev;
    end else begin
      stat_r <= stat_r | ev;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_r <= '0;
    end else if (sw_wr && sw_addr == usb_pipe_pkg::OFS_IRQ_MASK) begin
      mask_r <= sw_wdata[usb_pipe_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(stat_r & mask_r);

  // ------------------------------------------------------------------------
  // read data, registered one cycle after the strobe
  // ------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (sw_rd && dev_sel) begin
      rdata_r <= blk ? 32'h0000_0000 : bus.rdata;
    end else if (sw_rd && sw_addr == usb_pipe_pkg::OFS_IRQ_STAT) begin
      rdata_r <= 32'(stat_r);
    end else if (sw_rd && sw_addr == usb_pipe_pkg::OFS_IRQ_MASK) begin
      rdata_r <= 32'(mask_r);
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  assign sw_rdata = rdata_r;

endmodule : usb_pipe_host

// [usb_pipe_chk.sv]
// checker: field and timing relations on the pipe FIFO port link
`timescale 1ns/1ps
module usb_pipe_chk (
  input wire logic        sys_clk,  // system clock
  input wire logic        rst,      // async reset
  input wire logic        req,      // access strobe
  input wire logic        wr,       // write select
  input wire logic [5:0]  addr,     // byte offset
  input wire logic [31:0] wdata,    // write data
  input wire logic [3:0]  be,       // byte lanes
  input wire logic [31:0] rdata,    // read data
  input wire logic        rej,      // write refused
  input wire logic        rdy_evt   // buffer end pulse
);
  logic [3:0] sel_r;
  logic [3:0] cur_r;
  wire rd_c = req && !wr && addr == usb_pipe_pkg::OFS_PORT_CTRL;
  wire wr_c = req && wr && addr == usb_pipe_pkg::OFS_PORT_CTRL;
  wire rd_g = req && !wr && addr == usb_pipe_pkg::OFS_PIPE_CFG;
  wire rd_s = req && !wr && addr == usb_pipe_pkg::OFS_PORT_STAT;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------------------------------------
  // pipe indices as the device saw them; indices above 9 are ignored
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_r <= 4'h0;
      cur_r <= 4'h0;
    end else if (req && wr && wdata[3:0] <= 4'h9) begin
      if (addr == usb_pipe_pkg::OFS_PIPE_SEL) sel_r <= wdata[3:0];
      if (wr_c) cur_r <= wdata[3:0];
    end
  end
  chk_rsv_read_zero: assert property (
    rd_c |-> rdata[9] == 1'b0 && rdata[7:4] == 4'h0) else $error("rsv");
  chk_bad_width_rej: assert property (
    wr_c && wdata[11:10] == 2'h3 |-> rej) else $error("width 11 taken");
  chk_order_readback: assert property (
    wr_c ##1 !(req && wr) ##1 rd_c |-> rdata[8] == $past(wdata[8], 2))
    else $error("byte order lost");
  chk_widen_kept: assert property (
    wr_c && rej ##1 !(req && wr) ##1 rd_c
    |-> rdata[11:10] != $past(wdata[11:10], 2)) else $error("width moved");
  chk_rdy_on_data: assert property (
    rdy_evt |-> req && addr == usb_pipe_pkg::OFS_PORT_DATA)
    else $error("ready pulse off data");
  chk_ptr_in_range: assert property (
    rd_s |-> rdata[11:0] < rdata[27:16]) else $error("pointer past end");
  chk_small_pipe_cfg: assert property (
    rd_g && sel_r >= 4'h6 |-> rdata[10:7] == 4'h0) else $error("cfg 6..9");
  chk_ctrl_pipe_cfg: assert property (
    rd_g && sel_r == 4'h0 |-> rdata[15:14] == 2'h0 && rdata[3:0] == 4'h0)
    else $error("cfg pipe 0");
  chk_fixed_size: assert property (
    rd_s && (cur_r == 4'h0 || cur_r >= 4'h6) |-> rdata[27:16] == (cur_r ==
    4'h0 ? usb_pipe_pkg::CTRL_BYTES : usb_pipe_pkg::SMALL_BYTES))
    else $error("fixed size");
  cover property (rdy_evt);
  cover property (wr_c && rej);
  cover property (rd_g && sel_r >= 4'h6);
endmodule : usb_pipe_chk

// [usb_pipe_fifo_port_config_tb.sv]
// testbench: both pipe ends joined, software port checked against a model
`timescale 1ns/1ps
module usb_pipe_fifo_port_config_tb;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  sw_addr = 6'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic [3:0]  sw_be = 4'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic        irq;
  logic [31:0] v;
  logic        q;
  logic [7:0]  m [$];
  int          errors = 0;
  int          comparisons = 0;
  fifo_port_if bus ();
  usb_pipe_dev u_usb_pipe_dev (.sys_clk(sys_clk), .rst(rst), .bus(bus));
  usb_pipe_host u_usb_pipe_host (.sys_clk(sys_clk), .rst(rst), .bus(bus),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_be(sw_be), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq(irq));
  usb_pipe_chk u_usb_pipe_chk (.sys_clk(sys_clk), .rst(rst), .req(bus.req),
    .wr(bus.wr), .addr(bus.addr), .wdata(bus.wdata), .be(bus.be),
    .rdata(bus.rdata), .rej(bus.rej), .rdy_evt(bus.rdy_evt));
  always #25 sys_clk = ~sys_clk;
  task automatic acc(logic w, logic [5:0] a, logic [31:0] d, logic [3:0] b);
    @(posedge sys_clk);
    sw_wr <= w;
    sw_rd <= !w;
    sw_addr <= a;
    sw_wdata <= d;
    sw_be <= b;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1;
  endtask : acc
  task automatic check(string nm, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic rd(logic [5:0] a, logic [31:0] e);
    acc(1'b0, a, 32'h0, 4'h0);
    check($sformatf("reg %h", a), e, sw_rdata);
  endtask : rd
  function automatic logic [31:0] cfg_exp(int p, logic [31:0] w);
    logic [31:0] k;
    k = 32'h10;
    if (p > 0) k = k | 32'hC00F;
    if (p > 0 && p < 6) k = k | 32'h600;
    if ((p > 2 && p < 6) || (p > 0 && p < 3 && w[15:14] == 2'h1))
      k = k | 32'h180;
    return w & k;
  endfunction : cfg_exp
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    #2000000;
    errors++;
    conclude();
  end
  initial begin
    void'($urandom(23));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    rd(6'h00, 32'h0);
    rd(6'h3C, 32'h0);
    rd(6'h14, 32'h0100_0000);
    acc(1'b1, 6'h00, 32'h2, 4'h0);
    acc(1'b1, 6'h04, $urandom, 4'h1);
    rd(6'h20, 32'h4);
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 6'h00, {20'h0, 2'(c), 10'h3F0}, 4'h0);
      rd(6'h00, {20'h0, c == 3 ? 2'h2 : 2'(c), 10'h100});
    end
    rd(6'h20, 32'h6);
    acc(1'b1, 6'h24, 32'h0, 4'h0);
    q = irq;
    acc(1'b1, 6'h24, 32'h7, 4'h0);
    check("irq mask", {31'h0, !q}, {31'h0, irq});
    acc(1'b1, 6'h20, 32'h7, 4'h0);
    rd(6'h20, 32'h0);
    check("irq clear", 32'h0, {31'h0, irq});
    for (int p = 0; p < 10; p++) begin
      v = $urandom;
      v[3:0] = 4'(p + 1);
      acc(1'b1, 6'h08, 32'(p), 4'h0);
      acc(1'b1, 6'h0C, v, 4'h0);
      rd(6'h0C, cfg_exp(p, v));
      v = {17'h0, 5'(p * 6), 3'h0, 7'($urandom_range(8, 127))};
      acc(1'b1, 6'h10, v, 4'h0);
      acc(1'b1, 6'h10, v & 32'h7C00 | 32'h5, 4'h0);
      if (p > 0 && p < 6) rd(6'h10, v);
      acc(1'b1, 6'h00, 32'(p), 4'h0);
      if (p > 5) rd(6'h14, 32'h0040_0000);
    end
    acc(1'b1, 6'h08, 32'h1, 4'h0);
    acc(1'b1, 6'h0C, 32'h4011, 4'h0);
    acc(1'b1, 6'h10, 32'h8, 4'h0);
    acc(1'b1, 6'h00, 32'h1, 4'h0);
    acc(1'b1, 6'h20, 32'h7, 4'h0);
    for (int i = 0; i < 64; i++) begin
      v = $urandom;
      m.push_back(v[7:0]);
      acc(1'b1, 6'h04, v, 4'hF >> $urandom_range(0, 3));
      if (i == 0) acc(1'b1, 6'h00, 32'h801, 4'h0);
      if (i == 0) rd(6'h00, 32'h1);
    end
    rd(6'h20, 32'h3);
    acc(1'b1, 6'h00, 32'h901, 4'h0);
    for (int i = 0; i < 64; i += 4)
      rd(6'h04, {m[i], m[i + 1], m[i + 2], m[i + 3]});
    // odd partial write, then the same pipe turned round to receive
    acc(1'b1, 6'h00, 32'h4801, 4'h0);
    v = $urandom;
    acc(1'b1, 6'h04, v, 4'h7);
    rd(6'h14, 32'h0040_0003);
    acc(1'b1, 6'h0C, 32'h4001, 4'h0);
    acc(1'b1, 6'h00, 32'h4001, 4'h0);
    rd(6'h04, {24'h0, v[7:0]});
    acc(1'b1, 6'h00, 32'h401, 4'h0);
    rd(6'h20, 32'h7);
    rd(6'h00, 32'h1);
    acc(1'b1, 6'h00, 32'h4401, 4'h0);
    rd(6'h00, 32'h401);
    rd(6'h04, {16'h0, v[15:0]});
    conclude();
  end
endmodule : usb_pipe_fifo_port_config_tb
